// ### src/glitch_filter.sv
// ********************************************************
// two-flop synchroniser followed by a spike filter
// ********************************************************
module glitch_filter (
   input wire logic clk,
   input wire logic rst,
   input wire logic raw,
   output logic clean
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic [1:0] cnt;
   } filt_state_t;

   filt_state_t cur;
   filt_state_t next_cur;

   // a new level must persist for two samples, which rejects single-sample spikes
   always_comb begin
      next_cur = cur;
      next_cur.sync1 = raw;
      next_cur.sync2 = cur.sync1;
      if (cur.sync2 == cur.level) begin
         next_cur.cnt = 2'h0;
      end else if (cur.cnt == wiper_pkg::FILTER_LAST) begin
         next_cur.level = cur.sync2;
         next_cur.cnt = 2'h0;
      end else begin
         next_cur.cnt = cur.cnt + 2'h1;
      end
   end

   // idle bus reads high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, cnt: 2'h0};
      end else begin
         cur <= next_cur;
      end
   end

   assign clean = cur.level;

endmodule

// ### src/wiper_i2c_slave.sv
// ********************************************************
// serial slave controlling a 128-step wiper register
// ********************************************************
module wiper_i2c_slave (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic supply_above_trip,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic [6:0] wiper_tap,
   output logic [127:0] tap_select,
   output logic interface_static,
   output logic serial_enabled
);

   // ********************************************************
   // helper functions
   // ********************************************************

   // tap index n drives select line n; line 0 sits on terminal B
   function automatic logic [127:0] one_hot_tap(input logic [6:0] value);
      logic [127:0] sel;
      sel = 128'h0;
      sel[value] = 1'b1;
      return sel;
   endfunction

   // read byte carries the wiper in its low seven bits
   function automatic logic [7:0] read_byte(input logic [6:0] value);
      return {1'b0, value};
   endfunction

   // ********************************************************
   // link domain reset
   // ********************************************************
   logic link_rst_s1;
   logic link_rst;

   // asserts at once, releases on the link clock to avoid a ragged release
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link_rst_s1 <= 1'b1;
         link_rst <= 1'b1;
      end else begin
         link_rst_s1 <= 1'b0;
         link_rst <= link_rst_s1;
      end
   end

   // ********************************************************
   // filtered bus inputs
   // ********************************************************
   logic scl;
   logic sda;

   // both lines pass the same filter so their relative timing is kept
   glitch_filter scl_filter (
      .clk(link_clk),
      .rst(link_rst),
      .raw(scl_i),
      .clean(scl)
   );

   glitch_filter sda_filter (
      .clk(link_clk),
      .rst(link_rst),
      .raw(sda_i),
      .clean(sda)
   );

   // ********************************************************
   // link domain state
   // ********************************************************
   typedef struct packed {
      logic supply_s1;
      logic supply_s2;
      logic scl_q;
      logic sda_q;
      wiper_pkg::link_state_t state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [6:0] wiper;
      logic drive_low;
      logic is_read;
      logic master_ack;
      logic in_static;
      logic sda_out;
      logic scl_out;
      logic scl_drive;
   } link_reg_t;

   link_reg_t lnk;
   link_reg_t next_lnk;

   // ********************************************************
   // bus events
   // ********************************************************
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // edges of the filtered lines, one link cycle apart
   assign scl_rise = scl & ~lnk.scl_q;
   assign scl_fall = ~scl & lnk.scl_q;

   // data edge with clock held high on both samples
   assign start_seen = scl & lnk.scl_q & lnk.sda_q & ~sda;
   assign stop_seen = scl & lnk.scl_q & ~lnk.sda_q & sda;

   // ********************************************************
   // command engine
   // ********************************************************

   // apart from the release on a start, a stop or a supply drop, the data line is only ever updated on a falling
   // clock, so it is settled long before the next rising clock and no stretching is needed
   always_comb begin
      next_lnk = lnk;
      next_lnk.supply_s1 = supply_above_trip;
      next_lnk.supply_s2 = lnk.supply_s1;
      next_lnk.scl_q = scl;
      next_lnk.sda_q = sda;
      next_lnk.sda_out = 1'b0;
      next_lnk.scl_out = 1'b0;
      next_lnk.scl_drive = 1'b0;
      if (!lnk.supply_s2) begin
         // below trip: bus ignored, wiper held at default for the rise
         next_lnk.state = wiper_pkg::ST_IDLE;
         next_lnk.drive_low = 1'b0;
         next_lnk.bit_cnt = 4'h0;
         next_lnk.in_static = 1'b1;
         next_lnk.wiper = wiper_pkg::WIPER_DEFAULT;
      end else if (start_seen) begin
         // a start from any state restarts the command, error or not
         next_lnk.state = wiper_pkg::ST_ADDR;
         next_lnk.bit_cnt = 4'h0;
         next_lnk.drive_low = 1'b0;
         next_lnk.in_static = 1'b0;
      end else if (stop_seen) begin
         // pending data not yet acknowledged is simply dropped
         next_lnk.state = wiper_pkg::ST_IDLE;
         next_lnk.drive_low = 1'b0;
         next_lnk.in_static = 1'b1;
      end else begin
         // above the trip point every region accepts commands
         case (lnk.state)
            wiper_pkg::ST_IDLE: begin
               next_lnk.drive_low = 1'b0;
            end
            wiper_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  next_lnk.shift = {lnk.shift[6:0], sda};
                  next_lnk.bit_cnt = lnk.bit_cnt + 4'h1;
               end
               if (scl_fall && lnk.bit_cnt == wiper_pkg::BYTE_DONE) begin
                  if (lnk.shift[7:1] == wiper_pkg::SLAVE_ADDR) begin
                     next_lnk.drive_low = 1'b1;
                     next_lnk.is_read = lnk.shift[0];
                     next_lnk.state = wiper_pkg::ST_ADDR_ACK;
                  end else begin
                     // other targets, general call included, are left alone
                     next_lnk.drive_low = 1'b0;
                     next_lnk.state = wiper_pkg::ST_IGNORE;
                  end
               end
            end
            wiper_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  next_lnk.bit_cnt = 4'h0;
                  if (lnk.is_read) begin
                     next_lnk.shift = read_byte(lnk.wiper);
                     next_lnk.drive_low = ~next_lnk.shift[7];
                     next_lnk.state = wiper_pkg::ST_RD_DATA;
                  end else begin
                     next_lnk.drive_low = 1'b0;
                     next_lnk.state = wiper_pkg::ST_WR_DATA;
                  end
               end
            end
            wiper_pkg::ST_WR_DATA: begin
               if (scl_rise) begin
                  next_lnk.shift = {lnk.shift[6:0], sda};
                  next_lnk.bit_cnt = lnk.bit_cnt + 4'h1;
               end
               if (scl_fall && lnk.bit_cnt == wiper_pkg::BYTE_DONE) begin
                  next_lnk.drive_low = 1'b1;
                  next_lnk.state = wiper_pkg::ST_WR_ACK;
               end
            end
            wiper_pkg::ST_WR_ACK: begin
               if (scl_rise) begin
                  // commit inside the acknowledge clock, top data bit dropped
                  next_lnk.wiper = lnk.shift[6:0];
               end
               if (scl_fall) begin
                  next_lnk.drive_low = 1'b0;
                  next_lnk.bit_cnt = 4'h0;
                  next_lnk.state = wiper_pkg::ST_WR_DATA;
               end
            end
            wiper_pkg::ST_RD_DATA: begin
               if (scl_fall) begin
                  if (lnk.bit_cnt == wiper_pkg::LAST_TX_BIT) begin
                     next_lnk.drive_low = 1'b0;
                     next_lnk.state = wiper_pkg::ST_RD_ACK;
                  end else begin
                     next_lnk.shift = {lnk.shift[6:0], 1'b0};
                     next_lnk.drive_low = ~lnk.shift[6];
                     next_lnk.bit_cnt = lnk.bit_cnt + 4'h1;
                  end
               end
            end
            wiper_pkg::ST_RD_ACK: begin
               if (scl_rise) begin
                  next_lnk.master_ack = ~sda;
               end
               if (scl_fall) begin
                  if (lnk.master_ack) begin
                     next_lnk.shift = read_byte(lnk.wiper);
                     next_lnk.drive_low = ~next_lnk.shift[7];
                     next_lnk.bit_cnt = 4'h0;
                     next_lnk.state = wiper_pkg::ST_RD_DATA;
                  end else begin
                     next_lnk.drive_low = 1'b0;
                     next_lnk.state = wiper_pkg::ST_IGNORE;
                  end
               end
            end
            wiper_pkg::ST_IGNORE: begin
               // released line; only a new start can revive the engine
               next_lnk.drive_low = 1'b0;
            end
            default: begin
               next_lnk.drive_low = 1'b0;
               next_lnk.state = wiper_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // ********************************************************
   // link domain registers
   // ********************************************************

   // wiper starts at mid-scale; the bus lines are assumed idle high
   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         lnk <= '{
            supply_s1: 1'b0,
            supply_s2: 1'b0,
            scl_q: 1'b1,
            sda_q: 1'b1,
            state: wiper_pkg::ST_IDLE,
            bit_cnt: 4'h0,
            shift: 8'h00,
            wiper: wiper_pkg::WIPER_DEFAULT,
            drive_low: 1'b0,
            is_read: 1'b0,
            master_ack: 1'b0,
            in_static: 1'b1,
            sda_out: 1'b0,
            scl_out: 1'b0,
            scl_drive: 1'b0
         };
      end else begin
         lnk <= next_lnk;
      end
   end

   // open drain: output level is always low, only the enable toggles
   assign sda_o = lnk.sda_out;
   assign sda_oe = lnk.drive_low;
   assign scl_o = lnk.scl_out;
   assign scl_oe = lnk.scl_drive;

   // ********************************************************
   // crossing into the system clock
   // ********************************************************
   logic [6:0] wiper_word;

   // the wiper is a word, so it crosses by handshake rather than bit flops
   word_sync_cdc wiper_cross (
      .src_clk(link_clk),
      .src_rst(link_rst),
      .src_word(lnk.wiper),
      .dst_clk(clk),
      .dst_rst(sys_rst),
      .dst_word(wiper_word)
   );

   assign wiper_tap = wiper_word;

   // ********************************************************
   // system clock state
   // ********************************************************
   typedef struct packed {
      logic static_s1;
      logic static_s2;
      logic enab_s1;
      logic enab_s2;
      logic [127:0] tap_sel;
   } sys_reg_t;

   sys_reg_t sys;
   sys_reg_t next_sys;

   // levels cross through plain two-flop synchronisers; the tap decode
   // lags the wiper word by one clock
   always_comb begin
      next_sys = sys;
      next_sys.static_s1 = lnk.in_static;
      next_sys.static_s2 = sys.static_s1;
      next_sys.enab_s1 = supply_above_trip;
      next_sys.enab_s2 = sys.enab_s1;
      next_sys.tap_sel = one_hot_tap(wiper_word);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sys <= '{
            static_s1: 1'b1,
            static_s2: 1'b1,
            enab_s1: 1'b0,
            enab_s2: 1'b0,
            tap_sel: 128'h0000_0000_0000_0000_8000_0000_0000_0000
         };
      end else begin
         sys <= next_sys;
      end
   end

   // select line 0 is terminal B, line 127 is terminal A
   assign tap_select = sys.tap_sel;
   assign interface_static = sys.static_s2;
   assign serial_enabled = sys.enab_s2;

endmodule

// ### src/wiper_pkg.sv
package wiper_pkg;

   // ********************************************************
   // wiper and address
   // ********************************************************
   localparam logic [6:0] SLAVE_ADDR = 7'h2F;
   localparam logic [6:0] WIPER_DEFAULT = 7'h3F;
   localparam logic [6:0] WIPER_ZERO_SCALE = 7'h00;
   localparam logic [6:0] WIPER_FULL_SCALE = 7'h7F;
   localparam int TAP_COUNT = 128;

   // ********************************************************
   // bit counting and timing
   // ********************************************************
   localparam logic [3:0] BYTE_DONE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   localparam int LINK_PERIOD_NS = 160;
   localparam int FAST_BIT_NS = 2500;
   localparam int SAMPLES_PER_BIT = FAST_BIT_NS / LINK_PERIOD_NS;
   localparam logic [1:0] FILTER_LAST = 2'h1;

   // ********************************************************
   // link state machine
   // ********************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_DATA,
      ST_WR_ACK,
      ST_RD_DATA,
      ST_RD_ACK,
      ST_IGNORE
   } link_state_t;

endpackage

// ### src/word_sync_cdc.sv
// ********************************************************
// toggle handshake carrying the wiper word to another clock
// ********************************************************
module word_sync_cdc (
   input wire logic src_clk,
   input wire logic src_rst,
   input wire logic [6:0] src_word,
   input wire logic dst_clk,
   input wire logic dst_rst,
   output logic [6:0] dst_word
);

   typedef struct packed {
      logic [6:0] data;
      logic req;
      logic ack_s1;
      logic ack_s2;
   } src_state_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic ack;
      logic [6:0] word;
   } dst_state_t;

   src_state_t src;
   src_state_t next_src;
   dst_state_t dst;
   dst_state_t next_dst;

   // data stays frozen while a toggle is outstanding, so the far side reads it stable
   always_comb begin
      next_src = src;
      next_src.ack_s1 = dst.ack;
      next_src.ack_s2 = src.ack_s1;
      if ((src.req == src.ack_s2) && (src_word != src.data)) begin
         next_src.data = src_word;
         next_src.req = ~src.req;
      end
   end

   always_ff @(posedge src_clk or posedge src_rst) begin
      if (src_rst) begin
         src <= '{data: wiper_pkg::WIPER_DEFAULT, req: 1'b0, ack_s1: 1'b0, ack_s2: 1'b0};
      end else begin
         src <= next_src;
      end
   end

   // capture on the edge of the synchronised toggle, then echo it back
   always_comb begin
      next_dst = dst;
      next_dst.req_s1 = src.req;
      next_dst.req_s2 = dst.req_s1;
      next_dst.req_s3 = dst.req_s2;
      if (dst.req_s2 != dst.req_s3) begin
         next_dst.word = src.data;
         next_dst.ack = dst.req_s2;
      end
   end

   always_ff @(posedge dst_clk or posedge dst_rst) begin
      if (dst_rst) begin
         dst <= '{req_s1: 1'b0, req_s2: 1'b0, req_s3: 1'b0, ack: 1'b0,
                  word: wiper_pkg::WIPER_DEFAULT};
      end else begin
         dst <= next_dst;
      end
   end

   assign dst_word = dst.word;

endmodule

// ### tb/bus_master.sv
// ********
// bus master, pulls lines low only
// ********
module bus_master (
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // lines released while idle
   initial begin
      scl_oe = 1'h0;
      sda_oe = 1'h0;
   end
   // 800 ns steps: 1.6 us low phase, 2.4 us bit, just over the fast-mode rate
   task automatic start_bit();
      #800 scl_oe = 1'h0;
      #800 sda_oe = 1'h1;
      #800 scl_oe = 1'h1;
   endtask
   task automatic stop_bit();
      #800 sda_oe = 1'h1;
      #800 scl_oe = 1'h0;
      #800 sda_oe = 1'h0;
   endtask
   // data set in the low phase, read at the end of the high phase
   task automatic bit_io(input logic b, output logic r);
      #800 sda_oe = !b;
      #800 scl_oe = 1'h0;
      #800 r = sda;
      scl_oe = 1'h1;
   endtask
   // n bits msb first; a full byte also gets the ninth clock, data released
   task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q, output logic k);
      q = 8'h00;
      k = 1'h1;
      for (int i = 7; i > 7 - n; i--)
         bit_io(d[i], q[i]);
      if (n == 8)
         bit_io(1'h1, k);
   endtask
endmodule

// ### tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // ********
   // clocks, wires, model
   // ********
   logic clk = 1'h0;
   logic link_clk = 1'h0;
   logic sys_rst = 1'h0;
   logic supply_above_trip = 1'h1;
   logic m_scl;
   logic m_sda;
   logic scl_oe;
   logic sda_oe;
   logic is_static;
   logic enabled;
   logic [6:0] wiper_tap;
   logic [127:0] tap_select;
   logic [7:0] q;
   logic a;
   logic [6:0] v;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   int exp_wiper = 32'h3F;
   always #2.5 clk = ~clk;
   // link edges fall only on clk falling edges, never on rising clk edges or bus events
   always #80 link_clk = ~link_clk;
   // open-drain wires with pull-ups
   wire scl = !(m_scl || scl_oe);
   wire sda = !(m_sda || sda_oe);
   wiper_i2c_slave i_wiper_i2c_slave (
      .clk(clk),
      .sys_rst(sys_rst),
      .link_clk(link_clk),
      .supply_above_trip(supply_above_trip),
      .scl_i(scl),
      .scl_o(),
      .scl_oe(scl_oe),
      .sda_i(sda),
      .sda_o(),
      .sda_oe(sda_oe),
      .wiper_tap(wiper_tap),
      .tap_select(tap_select),
      .interface_static(is_static),
      .serial_enabled(enabled)
   );
   bus_master i_bus_master (
      .scl(scl),
      .sda(sda),
      .scl_oe(m_scl),
      .sda_oe(m_sda)
   );
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // the 1 ns step keeps samples off the clk edge
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check_wiper();
      check("wiper", wiper_tap, exp_wiper[6:0]);
      check("tap", tap_select, 128'h1 << exp_wiper);
   endtask
   task automatic wr(input logic [7:0] d);
      i_bus_master.start_bit();
      // filter and sync delay can outlast the start hold, so look after the address
      i_bus_master.xfer({wiper_pkg::SLAVE_ADDR, 1'h0}, 8, q, a);
      check("busy", is_static, 1'h0);
      check("addr_ack", a, 1'h0);
      i_bus_master.xfer(d, 8, q, a);
      check("data_ack", a, 1'h0);
      i_bus_master.stop_bit();
      exp_wiper = int'(d[6:0]);
      pause(400);
      check("static", is_static, 1'h1);
   endtask
   // one byte read, master answers with not-acknowledge
   task automatic rd();
      i_bus_master.start_bit();
      i_bus_master.xfer({wiper_pkg::SLAVE_ADDR, 1'h1}, 8, q, a);
      check("rd_ack", a, 1'h0);
      i_bus_master.xfer(8'hFF, 8, q, a);
      check("rd_data", q, {1'h0, exp_wiper[6:0]});
      i_bus_master.stop_bit();
      pause(400);
   endtask
   task automatic bad(input logic [7:0] c);
      i_bus_master.start_bit();
      i_bus_master.xfer(c, 8, q, a);
      i_bus_master.stop_bit();
      pause(400);
   endtask
   // run ceiling above the ~76k cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         n_fail++;
         print_verdict();
      end
   end
   // a real rising edge at time zero resets the link side before its first clock
   initial begin
      sys_rst <= 1'h1;
      void'($urandom(4318));
      repeat (10) @(posedge clk);
      sys_rst <= 1'h0;
      pause(400);
      check("sda_idle", sda_oe, 1'h0);
      check("static_rst", is_static, 1'h1);
      check("enabled", enabled, 1'h1);
      check_wiper();
      wr(8'h00);
      check_wiper();
      wr(8'hFF);
      check_wiper();
      rd();
      bad(8'h00);
      check("gen_nack", a, 1'h1);
      v = 7'($urandom());
      if (v == wiper_pkg::SLAVE_ADDR)
         v = ~v;
      bad({v, 1'h0});
      check("addr_nack", a, 1'h1);
      // stop in mid data byte must not write
      i_bus_master.start_bit();
      i_bus_master.xfer({wiper_pkg::SLAVE_ADDR, 1'h0}, 8, q, a);
      i_bus_master.xfer(8'h12, 4, q, a);
      i_bus_master.stop_bit();
      pause(400);
      check_wiper();
      @(posedge clk);
      supply_above_trip <= 1'h0;
      pause(600);
      check("disabled", enabled, 1'h0);
      exp_wiper = 32'h3F;
      check_wiper();
      bad({wiper_pkg::SLAVE_ADDR, 1'h0});
      check("ignored", a, 1'h1);
      @(posedge clk);
      supply_above_trip <= 1'h1;
      pause(600);
      check_wiper();
      v = 7'($urandom());
      wr({1'h1, v});
      check_wiper();
      rd();
      print_verdict();
   end
endmodule

// ### tb/wiper_chk.sv
// ********
// bus and wiper checks
// ********
module wiper_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic [6:0] wiper_tap,
   input wire logic [127:0] tap_select,
   input wire logic interface_static,
   input wire logic serial_enabled
);
   timeunit 1ns;
   timeprecision 100ps;
   // link side: only pull-downs, no clock of our own
   property p_scl_never;
      @(posedge link_clk) disable iff (sys_rst) !scl_oe && !scl_o;
   endproperty
   a_scl_never: assert property (p_scl_never) else $error("clock line driven");
   property p_sda_low;
      @(posedge link_clk) disable iff (sys_rst) !sda_o;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("data driven high");
   // data may only move while the clock line is low
   property p_hold_high;
      @(posedge link_clk) disable iff (sys_rst) scl_i && $past(scl_i) |-> $stable(sda_oe);
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("data moved, clock high");
   // tap decode follows the wiper one clk later
   property p_tap;
      @(posedge clk) disable iff (sys_rst) tap_select == (128'h1 << $past(wiper_tap));
   endproperty
   a_tap: assert property (p_tap) else $error("tap not one-hot wiper");
   // supply events: default wiper on rise and within 400 clk after a fall
   property p_rise;
      @(posedge clk) disable iff (sys_rst)
         $rose(serial_enabled) |-> wiper_tap == wiper_pkg::WIPER_DEFAULT;
   endproperty
   a_rise: assert property (p_rise) else $error("no default at power-up");
   property p_fall;
      @(posedge clk) disable iff (sys_rst)
         $fell(serial_enabled) |-> ##[1:400] wiper_tap == wiper_pkg::WIPER_DEFAULT;
   endproperty
   a_fall: assert property (p_fall) else $error("no default at brown-out");
   // start leaves and stop enters the static state, filter delay allowed
   property p_start;
      @(posedge clk) disable iff (sys_rst)
         $fell(sda_i) && scl_i && serial_enabled |-> ##[1:400] !interface_static;
   endproperty
   a_start: assert property (p_start) else $error("start not seen");
   property p_stop;
      @(posedge clk) disable iff (sys_rst)
         $rose(sda_i) && scl_i && serial_enabled |-> ##[1:400] interface_static;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not seen");
   c_ack: cover property (@(posedge link_clk) disable iff (sys_rst) $rose(sda_oe));
   c_zero: cover property (@(posedge clk) disable iff (sys_rst) wiper_tap == 7'h00);
   c_full: cover property (@(posedge clk) disable iff (sys_rst) wiper_tap == 7'h7F);
endmodule

bind wiper_i2c_slave wiper_chk i_chk (
   .clk(clk),
   .sys_rst(sys_rst),
   .link_clk(link_clk),
   .scl_i(scl_i),
   .scl_o(scl_o),
   .scl_oe(scl_oe),
   .sda_i(sda_i),
   .sda_o(sda_o),
   .sda_oe(sda_oe),
   .wiper_tap(wiper_tap),
   .tap_select(tap_select),
   .interface_static(interface_static),
   .serial_enabled(serial_enabled)
);
